// File: port_io_defines.svh
// Constants for the port configuration bank: offsets, resets, masks.
// Assumes an 8-bit special-function address space and 8-bit data.
`ifndef PORT_IO_DEFINES_SVH
`define PORT_IO_DEFINES_SVH

`define PORT1_LATCH_OFS       8'h90
`define PORT2_LATCH_OFS       8'ha0
`define PORT3_LATCH_OFS       8'hb0
`define PORT1_OUT_MODE_OFS    8'ha5
`define PORT2_OUT_MODE_OFS    8'ha6
`define PORT0_SKIP_OFS        8'hd4
`define PORT1_SKIP_OFS        8'hd5
`define PORT2_SKIP_OFS        8'hd6
`define PORT1_IN_MODE_OFS     8'hf2
`define PORT2_IN_MODE_OFS     8'hf3
`define PORT3_IN_MODE_OFS     8'hf4

`define LATCH_RST             8'hff
`define IN_MODE_RST           8'hff
`define OUT_MODE_RST          8'h00
`define SKIP_RST              8'h00
`define PORT3_IN_MODE_MASK    8'h1f
`define UNMAPPED_RDATA        8'h00

`endif

// File: port_io_pkg.sv
// Types shared by the port configuration bank.
// Assumes three driven ports (1..3) handled as a packed array.
package port_io_pkg;
    typedef logic [7:0]      byte_t;
    typedef logic [2:0][7:0] port_vec_t;
    typedef enum logic [3:0] {
        SEL_NONE  = 4'b0000,
        SEL_LAT1  = 4'b0001,
        SEL_LAT2  = 4'b0010,
        SEL_LAT3  = 4'b0011,
        SEL_OUT1  = 4'b0100,
        SEL_OUT2  = 4'b0101,
        SEL_SKIP0 = 4'b0110,
        SEL_SKIP1 = 4'b0111,
        SEL_SKIP2 = 4'b1000,
        SEL_IN1   = 4'b1001,
        SEL_IN2   = 4'b1010,
        SEL_IN3   = 4'b1011
    } reg_sel_t;
endpackage

// File: port_io_config_bank.sv
// Configuration and pin logic for ports 1..3 plus the crossbar skip masks
// of ports 0..2. Registers sit on a plain strobe port; read data appear
// one cycle after the read strobe. Pin inputs are synchronous to mclk_i.
// Crossbar priority decoding, port 0 pins and the global crossbar bits
// live elsewhere; all but the port 0 pins arrive here as plain inputs.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "port_io_defines.svh"
module port_io_config_bank #(
    parameter int XBAR_P2_PINS = 4
) (
    // Clock, reset, enable
    input  wire logic                  mclk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  ce_i,
    // Register port
    input  wire logic [7:0]            addr_i,
    input  wire port_io_pkg::byte_t    wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    input  wire logic                  read_latch_i,
    output port_io_pkg::byte_t         rdata_o,
    // Global crossbar controls held elsewhere
    input  wire logic                  crossbar_enable_bit_i,
    input  wire logic                  weak_pullup_disable_bit_i,
    input  wire port_io_pkg::byte_t    port3_output_mode_i,
    // Peripheral routing from the crossbar, index 0..2 is port 1..3
    input  wire port_io_pkg::port_vec_t periph_sel_i,
    input  wire port_io_pkg::port_vec_t periph_data_i,
    // Pins, index 0..2 is port 1..3
    input  wire port_io_pkg::port_vec_t pin_in_i,
    output port_io_pkg::port_vec_t     pin_out_o,
    output port_io_pkg::port_vec_t     pin_oe_o,
    output port_io_pkg::port_vec_t     pullup_en_o,
    output port_io_pkg::port_vec_t     receiver_en_o,
    // Skip masks to the crossbar decoder, index 0..2 is port 0..2
    output port_io_pkg::port_vec_t     crossbar_skip_o
);
    import port_io_pkg::*;

    // Parameter sanity: port 2 has eight pins at most
    // Zero crossbar pins would leave the port 2 mask meaningless
    if (XBAR_P2_PINS < 1 || XBAR_P2_PINS > 8) begin : g_chk
        $error("XBAR_P2_PINS must lie in 1..8");
    end

    // Register state; port 3 output mode is held outside this block
    // Port 3 input-mode bits 7:5 keep their reset ones inside
    port_vec_t latch_q;
    port_vec_t in_mode_q;
    port_vec_t skip_q;
    byte_t     out1_q;
    byte_t     out2_q;
    byte_t     rdata_q;
    byte_t     rdata_d;
    reg_sel_t  sel;
    logic      wr_en;
    logic      rd_en;

    // Address decode; unknown offsets select nothing
    assign sel = (addr_i == `PORT1_LATCH_OFS)    ? SEL_LAT1  :
                 (addr_i == `PORT2_LATCH_OFS)    ? SEL_LAT2  :
                 (addr_i == `PORT3_LATCH_OFS)    ? SEL_LAT3  :
                 (addr_i == `PORT1_OUT_MODE_OFS) ? SEL_OUT1  :
                 (addr_i == `PORT2_OUT_MODE_OFS) ? SEL_OUT2  :
                 (addr_i == `PORT0_SKIP_OFS)     ? SEL_SKIP0 :
                 (addr_i == `PORT1_SKIP_OFS)     ? SEL_SKIP1 :
                 (addr_i == `PORT2_SKIP_OFS)     ? SEL_SKIP2 :
                 (addr_i == `PORT1_IN_MODE_OFS)  ? SEL_IN1   :
                 (addr_i == `PORT2_IN_MODE_OFS)  ? SEL_IN2   :
                 (addr_i == `PORT3_IN_MODE_OFS)  ? SEL_IN3   : SEL_NONE;
    // Strobes only count while the clock enable is high
    assign wr_en = wr_i & ce_i;
    assign rd_en = rd_i & ce_i;

    // Effective per-pin configuration
    port_vec_t push_pull;
    port_vec_t xbar_ok;
    port_vec_t drive_val;
    port_vec_t pin_view;
    port_vec_t oe;
    byte_t     p2_xbar_mask;
    port_vec_t port_skip;

    // Upper port 2 pins never reach the crossbar
    assign p2_xbar_mask = byte_t'((16'h1 << XBAR_P2_PINS) - 16'h1);
    // Skip mask per driven port; port 3 has no skip register at all
    assign port_skip    = {8'h00, skip_q[2], skip_q[1]};

    genvar p;
    for (p = 0; p < 3; p++) begin : g_port
        byte_t mode_raw;
        byte_t part;
        // Port 3 has no crossbar route; its output mode is held outside
        assign mode_raw = (p == 0) ? out1_q :
                          (p == 1) ? out2_q : port3_output_mode_i;
        assign part = (p == 0) ? 8'hff :
                      (p == 1) ? p2_xbar_mask : 8'h00;
        // Output mode only counts for digital pins
        assign push_pull[p] = mode_raw & in_mode_q[p];
        // A pin joins the crossbar only if not skipped
        assign xbar_ok[p]   = periph_sel_i[p] & part &
                              ~port_skip[p];
        assign drive_val[p] = (xbar_ok[p] & periph_data_i[p]) |
                              (~xbar_ok[p] & latch_q[p]);
        // Digital pins drive low always, high only when push-pull; crossbar off
        // wins over both, so the pins then act as inputs only
        assign oe[p] = {8{crossbar_enable_bit_i}} & in_mode_q[p] &
                       (push_pull[p] | ~drive_val[p]);
        assign pin_oe_o[p]  = oe[p];
        assign pin_out_o[p] = drive_val[p] & oe[p];
        // Pullup off while actively pulling low, saves sink current
        assign pullup_en_o[p] = in_mode_q[p] & ~push_pull[p] &
                                {8{~weak_pullup_disable_bit_i}} &
                                ~(oe[p] & ~drive_val[p]);
        assign receiver_en_o[p] = in_mode_q[p];
        // Analog pins read 1 whatever the voltage
        assign pin_view[p] = pin_in_i[p] | ~in_mode_q[p];
    end

    // Skip masks; port 2 upper pins always reported skipped
    assign crossbar_skip_o[0] = skip_q[0];
    assign crossbar_skip_o[1] = skip_q[1];
    assign crossbar_skip_o[2] = skip_q[2] | ~p2_xbar_mask;

    // Read mux; read-modify-write cycles see the stored latch
    always_comb begin
        case (sel)
            SEL_LAT1:  rdata_d = read_latch_i ? latch_q[0] : pin_view[0];
            SEL_LAT2:  rdata_d = read_latch_i ? latch_q[1] : pin_view[1];
            SEL_LAT3:  rdata_d = read_latch_i ? latch_q[2] : pin_view[2];
            SEL_OUT1:  rdata_d = out1_q;
            SEL_OUT2:  rdata_d = out2_q;
            SEL_SKIP0: rdata_d = skip_q[0];
            SEL_SKIP1: rdata_d = skip_q[1];
            SEL_SKIP2: rdata_d = skip_q[2];
            SEL_IN1:   rdata_d = in_mode_q[0];
            SEL_IN2:   rdata_d = in_mode_q[1];
            SEL_IN3:   rdata_d = in_mode_q[2] & `PORT3_IN_MODE_MASK;
            default:   rdata_d = `UNMAPPED_RDATA;
        endcase
    end

    // Latches and modes, one-cycle writes
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_q   <= {3{`LATCH_RST}};
            in_mode_q <= {3{`IN_MODE_RST}};
            out1_q    <= `OUT_MODE_RST;
            out2_q    <= `OUT_MODE_RST;
        end else if (wr_en) begin
            if (sel == SEL_LAT1) latch_q[0] <= wdata_i;
            if (sel == SEL_LAT2) latch_q[1] <= wdata_i;
            if (sel == SEL_LAT3) latch_q[2] <= wdata_i;
            if (sel == SEL_IN1)  in_mode_q[0] <= wdata_i;
            if (sel == SEL_IN2)  in_mode_q[1] <= wdata_i;
            // Unused bits keep their reset 1s internally but read 0
            if (sel == SEL_IN3)  in_mode_q[2][4:0] <= wdata_i[4:0];
            if (sel == SEL_OUT1) out1_q <= wdata_i;
            if (sel == SEL_OUT2) out2_q <= wdata_i;
        end
    end

    // Skip registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            skip_q <= {3{`SKIP_RST}};
        end else if (wr_en) begin
            if (sel == SEL_SKIP0) skip_q[0] <= wdata_i;
            if (sel == SEL_SKIP1) skip_q[1] <= wdata_i;
            if (sel == SEL_SKIP2) skip_q[2] <= wdata_i;
        end
    end

    // Read data live for one cycle after the strobe while ce_i stays high; ce_i low holds them
    // Zero between reads, so a late sample cannot pass for fresh data
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i) begin
            rdata_q <= rd_i ? rdata_d : 8'h00;
        end
    end
    assign rdata_o = rdata_q;

    // Checks. They run on the system clock and rest while reset is high.
    // Some watch internal nets, so a fault shows next to its cause rather
    // than several cycles later at a pin.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // A taken write, and a taken read of one register in a given mode
    sequence wr_to(reg_sel_t s);
        wr_en && sel == s;
    endsequence
    sequence rd_of(reg_sel_t s, logic lat);
        rd_en && sel == s && read_latch_i == lat;
    endsequence

    // Skip masks take the written byte at the strobe edge
    skip_store_a: assert property (
        wr_to(SEL_SKIP0) |=> crossbar_skip_o[0] == $past(wdata_i))
        else $error("skip mask not taken from write");
    skip1_store_a: assert property (
        wr_to(SEL_SKIP1) |=> crossbar_skip_o[1] == $past(wdata_i))
        else $error("port1 skip mask not taken from write");
    // A skipped pin is never handed to a peripheral
    skip_route_a: assert property (
        ((xbar_ok[0] & skip_q[1]) | (xbar_ok[1] & skip_q[2])) == 8'h00)
        else $error("skipped pin routed to crossbar");

    // With no peripheral and a full driver, the pin shows the new latch
    latch_drive_a: assert property (
        wr_to(SEL_LAT1) ##1 (periph_sel_i[0] == 8'h00 && oe[0] == 8'hff)
        |-> pin_out_o[0] == $past(wdata_i))
        else $error("pin does not follow latch write");
    // Any driven pin the crossbar does not claim follows its latch
    latch_pin_a: assert property (
        (pin_oe_o & ~xbar_ok & (pin_out_o ^ latch_q)) == '0)
        else $error("driven pin differs from latch");
    // Port 3 latch holds the written byte in the cycle after its strobe
    lat3_store_a: assert property (
        wr_to(SEL_LAT3) |=> latch_q[2] == $past(wdata_i))
        else $error("port3 latch write lost");

    // Open-drain pins never drive high, on any port
    od_float_a: assert property (
        (pin_oe_o[0] & drive_val[0] & ~push_pull[0]) == 8'h00)
        else $error("open-drain pin driven high");
    od_high_a: assert property (
        (pin_oe_o & pin_out_o & ~push_pull) == '0)
        else $error("open-drain pin drives high");

    // Analog pins read back as ones, digital pins read the pin level
    analog_one_a: assert property (
        rd_of(SEL_LAT1, 1'b0) |=>
        (rdata_o & ~$past(in_mode_q[0])) == ~$past(in_mode_q[0]))
        else $error("analog pin read not one");
    digital_pin_a: assert property (
        rd_of(SEL_LAT1, 1'b0) |=>
        (rdata_o & $past(in_mode_q[0])) ==
        ($past(pin_in_i[0]) & $past(in_mode_q[0])))
        else $error("digital pin read wrong");

    // Analog pins lose driver, pullup and receiver
    analog_off_a: assert property (
        ((pin_oe_o[1] | pullup_en_o[1] | receiver_en_o[1]) &
         ~in_mode_q[1]) == 8'h00)
        else $error("analog pin not isolated");
    rcv_mode_a: assert property (
        receiver_en_o == in_mode_q)
        else $error("receiver enable differs from mode");
    // Output mode is dropped on analog pins
    analog_pp_a: assert property (
        (push_pull & ~in_mode_q) == '0)
        else $error("output mode used on analog pin");

    // Push-pull digital pins are driven while the crossbar is on
    pp_drive_a: assert property (
        crossbar_enable_bit_i |->
        (pin_oe_o[0] & in_mode_q[0] & out1_q) == (in_mode_q[0] & out1_q))
        else $error("push-pull pin not driven");

    // Port 2 pins beyond the crossbar range stay skipped and unrouted
    p2_upper_a: assert property (
        (crossbar_skip_o[2] | p2_xbar_mask) == 8'hff &&
        (xbar_ok[1] & ~p2_xbar_mask) == 8'h00)
        else $error("port2 upper pin reached crossbar");

    // Port 3 unused mode bits read zero and keep their value
    p3_unused_a: assert property (
        rd_of(SEL_IN3, 1'b0) |=> rdata_o[7:5] == 3'b000)
        else $error("port3 unused mode bits read back");
    in3_keep_a: assert property (
        wr_to(SEL_IN3) |=> in_mode_q[2][7:5] == $past(in_mode_q[2][7:5]))
        else $error("port3 unused mode bits written");

    // Read-modify-write reads see the stored latch, not the pin
    rmw_latch_a: assert property (
        rd_of(SEL_LAT3, 1'b1) |=> rdata_o == $past(latch_q[2]))
        else $error("rmw read did not see latch");
    rmw1_latch_a: assert property (
        rd_of(SEL_LAT1, 1'b1) |=> rdata_o == $past(latch_q[0]))
        else $error("port1 rmw read did not see latch");

    // Crossbar off: no driver on, no level driven
    xbar_off_a: assert property (
        !crossbar_enable_bit_i |-> pin_oe_o == '0)
        else $error("driver on with crossbar disabled");
    xbar_out_a: assert property (
        !crossbar_enable_bit_i |-> pin_out_o == '0)
        else $error("level driven with crossbar disabled");

    // Weak pullups: on for idle open-drain pins, off while pulling low
    pullup_a: assert property (
        !weak_pullup_disable_bit_i && in_mode_q[0][0] && !push_pull[0][0]
        && !(oe[0][0] && !drive_val[0][0]) |-> pullup_en_o[0][0])
        else $error("weak pullup missing");
    pullup_low_a: assert property (
        (pullup_en_o & pin_oe_o & ~pin_out_o) == '0)
        else $error("pullup on while driving low");

    // Clock enable low: not a bit of state moves, read data included
    ce_hold_a: assert property (
        !ce_i |=> $stable(latch_q) && $stable(in_mode_q) &&
        $stable(skip_q) && $stable(out1_q) && $stable(out2_q) &&
        $stable(rdata_q))
        else $error("state moved with clock enable low");
    // Read data idle at zero, unmapped reads zero, writes land at once
    rd_idle_a: assert property (
        ce_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data not cleared");
    unmapped_zero_a: assert property (
        rd_en && sel == SEL_NONE |=> rdata_o == `UNMAPPED_RDATA)
        else $error("unmapped read not zero");
    in2_store_a: assert property (
        wr_to(SEL_IN2) |=> in_mode_q[1] == $past(wdata_i))
        else $error("port2 input mode write lost");
endmodule // port_io_config_bank

// File: port_io_config_bank_tb.sv
// Self-checking bench for the port configuration bank: register access,
// read-back, pin driver modes and crossbar skip routing.
// Assumes the strobe register port with read data one cycle after rd_i.
`timescale 1ns/1ps
`include "port_io_defines.svh"
module port_io_config_bank_tb;
    import port_io_pkg::*;
    logic       mclk_i, sys_rst_i, ce_i, wr_i, rd_i, read_latch_i;
    logic [7:0] addr_i;
    byte_t      wdata_i, rdata_o, port3_output_mode_i;
    logic       crossbar_enable_bit_i, weak_pullup_disable_bit_i;
    port_vec_t  periph_sel_i, periph_data_i, pin_in_i;
    port_vec_t  pin_out_o, pin_oe_o, pullup_en_o, receiver_en_o;
    port_vec_t  crossbar_skip_o;
    int         error_cnt, n_compared, cycles;
    // Register offsets and their reset values; port 3 mode hides 7:5
    logic [7:0] ofs [11] = '{`PORT1_LATCH_OFS, `PORT2_LATCH_OFS,
        `PORT3_LATCH_OFS, `PORT1_OUT_MODE_OFS, `PORT2_OUT_MODE_OFS,
        `PORT0_SKIP_OFS, `PORT1_SKIP_OFS, `PORT2_SKIP_OFS,
        `PORT1_IN_MODE_OFS, `PORT2_IN_MODE_OFS, `PORT3_IN_MODE_OFS};
    byte_t      rst_v [11] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hff, 8'hff, 8'h1f};

    port_io_config_bank dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .read_latch_i(read_latch_i), .rdata_o(rdata_o),
        .crossbar_enable_bit_i(crossbar_enable_bit_i),
        .weak_pullup_disable_bit_i(weak_pullup_disable_bit_i),
        .port3_output_mode_i(port3_output_mode_i),
        .periph_sel_i(periph_sel_i), .periph_data_i(periph_data_i),
        .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .pullup_en_o(pullup_en_o), .receiver_en_o(receiver_en_o),
        .crossbar_skip_o(crossbar_skip_o));

    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;

    // Hang guard: the whole sequence needs well under 1000 cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input byte_t seen, input byte_t exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobes drop on the taking edge; the next call waits an edge first
    task automatic reg_wr(input logic [7:0] a, input byte_t d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic rmw,
                          input byte_t exp);
        @(posedge mclk_i);
        addr_i       <= a;
        rd_i         <= 1'b1;
        read_latch_i <= rmw;
        @(posedge mclk_i);
        rd_i         <= 1'b0;
        read_latch_i <= 1'b0;
        #1 chk("read data", rdata_o, exp);
    endtask

    task automatic do_reset();
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
    endtask

    // Inputs change right after an edge, outputs are looked at 1 ns later
    task automatic set_ctl(input logic xbar, input logic wpd);
        @(posedge mclk_i);
        crossbar_enable_bit_i     <= xbar;
        weak_pullup_disable_bit_i <= wpd;
        #1;
    endtask

    initial begin
        mclk_i = 1'b0; sys_rst_i = 1'b1; ce_i = 1'b1; wr_i = 1'b0;
        rd_i = 1'b0; read_latch_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
        crossbar_enable_bit_i = 1'b0; weak_pullup_disable_bit_i = 1'b0;
        port3_output_mode_i = 8'h00; periph_sel_i = '0;
        periph_data_i = '0; pin_in_i = '0;
        do_reset();
        // Reset values, latches read through the stored value
        for (int i = 0; i < 11; i++)
            rd_chk(ofs[i], i < 3, rst_v[i]);
        chk("skip2 out", crossbar_skip_o[2], 8'hf0);
        chk("receiver1", receiver_en_o[0], 8'hff);
        // Write every register, poke an unmapped place, read all back
        for (int i = 0; i < 11; i++)
            reg_wr(ofs[i], 8'h5a);
        reg_wr(8'h91, 8'hff);
        for (int i = 0; i < 10; i++)
            rd_chk(ofs[i], i < 3, 8'h5a);
        rd_chk(`PORT3_IN_MODE_OFS, 1'b0, 8'h1a);
        rd_chk(8'h91, 1'b0, 8'h00);
        chk("skip0 out", crossbar_skip_o[0], 8'h5a);
        chk("skip2 out", crossbar_skip_o[2], 8'hfa);
        // Second reset in mid-run; then mixed analog and digital port 1
        do_reset();
        pin_in_i[0] <= 8'h3c;
        reg_wr(`PORT1_IN_MODE_OFS, 8'h0f);
        reg_wr(`PORT1_SKIP_OFS, 8'hf0);
        chk("skip1 analog", crossbar_skip_o[1], 8'hf0);
        reg_wr(`PORT1_LATCH_OFS, 8'h33);
        reg_wr(`PORT1_OUT_MODE_OFS, 8'h55);
        rd_chk(`PORT1_LATCH_OFS, 1'b0, 8'hfc);
        rd_chk(`PORT1_LATCH_OFS, 1'b1, 8'h33);
        chk("receiver1", receiver_en_o[0], 8'h0f);
        set_ctl(1'b1, 1'b0);
        chk("oe1", pin_oe_o[0], 8'h0d);
        chk("out1", pin_out_o[0], 8'h01);
        chk("pullup1", pullup_en_o[0], 8'h02);
        set_ctl(1'b1, 1'b1);
        chk("pullup1 off", pullup_en_o[0], 8'h00);
        set_ctl(1'b0, 1'b1);
        chk("oe1 xbar off", pin_oe_o[0], 8'h00);
        // Crossbar routing with skipped pins, port 2 upper pins, port 3
        reg_wr(`PORT1_IN_MODE_OFS, 8'hff);
        reg_wr(`PORT1_LATCH_OFS, 8'hff);
        reg_wr(`PORT1_OUT_MODE_OFS, 8'hff);
        reg_wr(`PORT1_SKIP_OFS, 8'hcf);
        reg_wr(`PORT2_OUT_MODE_OFS, 8'hff);
        @(posedge mclk_i);
        periph_sel_i  <= {3{8'hff}};
        periph_data_i <= '0;
        set_ctl(1'b1, 1'b0);
        chk("out1 xbar", pin_out_o[0], 8'hcf);
        chk("oe1 xbar", pin_oe_o[0], 8'hff);
        chk("out2 xbar", pin_out_o[1], 8'hf0);
        chk("oe3 xbar", pin_oe_o[2], 8'h00);
        chk("skip1 out", crossbar_skip_o[1], 8'hcf);
        // Plain latch output once peripherals let go of port 1
        @(posedge mclk_i);
        periph_sel_i <= '0;
        reg_wr(`PORT1_LATCH_OFS, 8'h96);
        chk("out1 latch", pin_out_o[0], 8'h96);
        // Clock enable low: a write must not land
        @(posedge mclk_i);
        ce_i <= 1'b0;
        reg_wr(`PORT0_SKIP_OFS, 8'h11);
        @(posedge mclk_i);
        ce_i <= 1'b1;
        rd_chk(`PORT0_SKIP_OFS, 1'b0, 8'h00);
        tally_and_finish();
    end
endmodule // port_io_config_bank_tb
